// >>> common/cpo_defs.svh
/*
  Register offsets, field positions, reset values and divider counts
  for the clock pin controller.
  Assumes byte addresses on a 32-bit Wishbone bus, one register a word.
*/
`ifndef CPO_DEFS_SVH
`define CPO_DEFS_SVH

`define CPO_ADR_W         6
`define CPO_IDX_XCFG      4'h0
`define CPO_IDX_CCTL      4'h1
`define CPO_IDX_MUX       4'h2
`define CPO_IDX_STAT      4'h3

`define CPO_DIV_LSB       0
`define CPO_DIV_MSB       1
`define CPO_PINSEL_BIT    6
`define CPO_XIN_OFF_BIT   13
`define CPO_XTAL_OFF_BIT  14
`define CPO_MUX18_BIT     0

`define CPO_XCFG_MASK     32'h0000_0043
`define CPO_CCTL_MASK     32'h0000_6000
`define CPO_MUX_MASK      32'h0000_0001
`define CPO_XCFG_RST      32'h0000_0000
`define CPO_CCTL_RST      32'h0000_0000
`define CPO_MUX_RST       32'h0000_0000

`define CPO_HALF_FULL     2'h0
`define CPO_HALF_HALF     2'h1
`define CPO_HALF_QUARTER  2'h3

`define CPO_ST_MODE_LSB   0
`define CPO_ST_CLK_BIT    2
`define CPO_ST_P19_BIT    3
`define CPO_ST_P38_BIT    4
`define CPO_ST_EXT_BIT    5

`endif

// >>> common/cpo_pkg.sv
/*
  Types shared by the clock pin controller files.
  Assumes cpo_defs.svh for all numeric constants.
*/
package cpo_pkg;

  // Encoding follows the divide field values 0..3 in order
  typedef enum logic [1:0] {
    CPO_DIV_QUARTER,
    CPO_DIV_HALF,
    CPO_DIV_FULL,
    CPO_DIV_OFF
  } cpo_div_e;

  typedef enum logic {
    CPO_BUS_IDLE,
    CPO_BUS_ACK
  } cpo_bus_e;

  typedef struct packed {
    logic [3:0]  idx;
    logic [31:0] data;
    logic [3:0]  sel;
  } cpo_wr_s;

endpackage

// >>> hw/cpo_sync.sv
/*
  Two flip-flop synchroniser for pin levels.
  Assumes inputs are asynchronous to clock; only the second stage is read.
*/
`timescale 1ns/1ps
module cpo_sync
  import cpo_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

// >>> hw/cpo_wb_slave.sv
/*
  Classic Wishbone slave front end: one wait state, ack for one cycle.
  Assumes the master holds a request until ack and drops it afterwards.
  Read data comes combinationally from the owner of the registers.
*/
`timescale 1ns/1ps
`include "cpo_defs.svh"
module cpo_wb_slave
  import cpo_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`CPO_ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  output logic      [3:0]             rd_idx,
  input  wire logic [31:0]            rd_data,
  output logic                        wr_valid,
  output cpo_wr_s                     wr
);

  cpo_bus_e    state_reg;
  cpo_bus_e    state_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        wrv_reg;
  logic        wrv_next;
  cpo_wr_s     wr_reg;
  cpo_wr_s     wr_next;

  assign rd_idx = wb_adr_i[5:2];

  always_comb
  begin
    state_next = state_reg;
    ack_next   = 1'b0;
    dat_next   = dat_reg;
    wrv_next   = 1'b0;
    wr_next    = wr_reg;
    case (state_reg)
      CPO_BUS_IDLE:
        if (wb_cyc_i && wb_stb_i)
        begin
          state_next = CPO_BUS_ACK;
          ack_next   = 1'b1;
          dat_next   = wb_we_i ? 32'h0000_0000 : rd_data;
          wrv_next   = wb_we_i;
          wr_next    = '{idx: wb_adr_i[5:2], data: wb_dat_i, sel: wb_sel_i};
        end
      CPO_BUS_ACK:
        state_next = CPO_BUS_IDLE;
      default:
        state_next = CPO_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= CPO_BUS_IDLE;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0000_0000;
      wrv_reg   <= 1'b0;
      wr_reg    <= '0;
    end
    else
    begin
      state_reg <= state_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      wrv_reg   <= wrv_next;
      wr_reg    <= wr_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign wr_valid = wrv_reg;
  assign wr       = wr_reg;

endmodule

// >>> hw/cpo_clock_pin_ctrl.sv
/*
  Clock pin controller: external clock pin selection, crystal and
  external-input enables, and a divided clock driven onto shared pin 18.
  Assumes clock is twice the system clock rate, so that a flip-flop can
  reproduce the system clock itself; software reaches the registers over
  classic Wishbone. Pin inputs are asynchronous and are synchronised here.
*/
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "cpo_defs.svh"
module cpo_clock_pin_ctrl
  import cpo_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`CPO_ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   shared_pin_19_in,
  input  wire logic                   shared_pin_38_in,
  output logic                        shared_pin_18_out,
  output logic                        shared_pin_18_oe,
  output logic                        external_oscillator_input,
  output logic                        crystal_osc_enable
);

  // Byte-lane merge, used for every writable register
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // Half period of the pin clock, in clock cycles minus one
  function automatic logic [1:0] half_count(input cpo_div_e mode);
    logic [1:0] h;
    case (mode)
      CPO_DIV_FULL:    h = `CPO_HALF_FULL;
      CPO_DIV_HALF:    h = `CPO_HALF_HALF;
      CPO_DIV_QUARTER: h = `CPO_HALF_QUARTER;
      default:         h = `CPO_HALF_QUARTER;
    endcase
    return h;
  endfunction

  // Bus front end
  logic [3:0]  rd_idx;
  logic [31:0] rd_data;
  logic        wr_valid;
  cpo_wr_s     wr;

  cpo_wb_slave u_bus (
    .clock    (clock),
    .rst_n    (rst_n),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .rd_idx   (rd_idx),
    .rd_data  (rd_data),
    .wr_valid (wr_valid),
    .wr       (wr)
  );

  // Pin synchronisers
  logic [1:0] pins_sync;

  cpo_sync #(
    .W (2)
  ) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({shared_pin_38_in, shared_pin_19_in}),
    .sync_out (pins_sync)
  );

  logic pin19_s;
  logic pin38_s;

  assign pin19_s = pins_sync[0];
  assign pin38_s = pins_sync[1];

  // Register file
  logic [31:0] xcfg_reg;
  logic [31:0] xcfg_next;
  logic [31:0] cctl_reg;
  logic [31:0] cctl_next;
  logic [31:0] mux_reg;
  logic [31:0] mux_next;

  always_comb
  begin
    xcfg_next = xcfg_reg;
    cctl_next = cctl_reg;
    mux_next  = mux_reg;
    if (wr_valid)
    begin
      case (wr.idx)
        `CPO_IDX_XCFG:
          xcfg_next = lane_merge(xcfg_reg, wr.data, wr.sel, `CPO_XCFG_MASK);
        `CPO_IDX_CCTL:
          cctl_next = lane_merge(cctl_reg, wr.data, wr.sel, `CPO_CCTL_MASK);
        `CPO_IDX_MUX:
          mux_next  = lane_merge(mux_reg, wr.data, wr.sel, `CPO_MUX_MASK);
        default:
          xcfg_next = xcfg_reg;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xcfg_reg <= `CPO_XCFG_RST;
      cctl_reg <= `CPO_CCTL_RST;
      mux_reg  <= `CPO_MUX_RST;
    end
    else
    begin
      xcfg_reg <= xcfg_next;
      cctl_reg <= cctl_next;
      mux_reg  <= mux_next;
    end
  end

  cpo_div_e div_field;
  logic     pin_select;
  logic     xin_off;
  logic     xtal_off;
  logic     mux18_clk;

  assign div_field  = cpo_div_e'(xcfg_reg[`CPO_DIV_MSB:`CPO_DIV_LSB]);
  assign pin_select = xcfg_reg[`CPO_PINSEL_BIT];
  assign xin_off    = cctl_reg[`CPO_XIN_OFF_BIT];
  assign xtal_off   = cctl_reg[`CPO_XTAL_OFF_BIT];
  assign mux18_clk  = mux_reg[`CPO_MUX18_BIT];

  // Divider. A change of divide field restarts the phase with the clock low,
  // so a high phase in progress can be cut short to a single clock cycle.
  cpo_div_e   mode_reg;
  cpo_div_e   mode_next;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       div_clk_reg;
  logic       div_clk_next;

  always_comb
  begin
    mode_next    = div_field;
    cnt_next     = cnt_reg;
    div_clk_next = div_clk_reg;
    if (div_field != mode_reg || div_field == CPO_DIV_OFF)
    begin
      cnt_next     = 2'h0;
      div_clk_next = 1'b0;
    end
    else if (cnt_reg >= half_count(mode_reg))
    begin
      cnt_next     = 2'h0;
      div_clk_next = ~div_clk_reg;
    end
    else
    begin
      cnt_next = cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg    <= CPO_DIV_QUARTER;
      cnt_reg     <= 2'h0;
      div_clk_reg <= 1'b0;
    end
    else
    begin
      mode_reg    <= mode_next;
      cnt_reg     <= cnt_next;
      div_clk_reg <= div_clk_next;
    end
  end

  // Pin stage. Pin 18 is left undriven unless its mux selects the clock,
  // since other functions of that pin live outside this block.
  logic pin18_out_reg;
  logic pin18_out_next;
  logic pin18_oe_reg;
  logic pin18_oe_next;
  logic ext_in_reg;
  logic ext_in_next;
  logic xtal_en_reg;
  logic xtal_en_next;

  always_comb
  begin
    pin18_oe_next  = mux18_clk;
    pin18_out_next = mux18_clk & div_clk_reg;
    // Select 0 is pin 38, the reset default
    ext_in_next    = ~xin_off & (pin_select ? pin19_s : pin38_s);
    // Disabling the crystal also serves as the debug-time escape
    xtal_en_next   = ~xtal_off;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin18_out_reg <= 1'b0;
      pin18_oe_reg  <= 1'b0;
      ext_in_reg    <= 1'b0;
      xtal_en_reg   <= 1'b1;
    end
    else
    begin
      pin18_out_reg <= pin18_out_next;
      pin18_oe_reg  <= pin18_oe_next;
      ext_in_reg    <= ext_in_next;
      xtal_en_reg   <= xtal_en_next;
    end
  end

  assign shared_pin_18_out         = pin18_out_reg;
  assign shared_pin_18_oe          = pin18_oe_reg;
  assign external_oscillator_input = ext_in_reg;
  assign crystal_osc_enable        = xtal_en_reg;

  // Read side. Unmapped words read as zero and ignore writes.
  logic [31:0] status;

  always_comb
  begin
    status = 32'h0000_0000;
    status[`CPO_ST_MODE_LSB +: 2] = mode_reg;
    status[`CPO_ST_CLK_BIT]       = div_clk_reg;
    status[`CPO_ST_P19_BIT]       = pin19_s;
    status[`CPO_ST_P38_BIT]       = pin38_s;
    status[`CPO_ST_EXT_BIT]       = ext_in_reg;
  end

  always_comb
  begin
    case (rd_idx)
      `CPO_IDX_XCFG: rd_data = xcfg_reg;
      `CPO_IDX_CCTL: rd_data = cctl_reg;
      `CPO_IDX_MUX:  rd_data = mux_reg;
      `CPO_IDX_STAT: rd_data = status;
      default:       rd_data = 32'h0000_0000;
    endcase
  end

endmodule

// >>> test/cpo_props.sv
/* Port checker for the clock pin controller.
   Assumes it is bound to cpo_clock_pin_ctrl and sees only its ports. */
`timescale 1ns/1ps
`include "cpo_defs.svh"
module cpo_props
  import cpo_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [`CPO_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic                  shared_pin_19_in,
  input wire logic                  shared_pin_38_in,
  input wire logic                  shared_pin_18_out,
  input wire logic                  shared_pin_18_oe,
  input wire logic                  external_oscillator_input,
  input wire logic                  crystal_osc_enable
);
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] div_reg, div_next;
  logic       sel_reg, sel_next, mux_reg, mux_next;
  logic       xoff_reg, xoff_next, xtal_reg, xtal_next;
  logic       wr, w0, w1, pin_v;
  logic [3:0] idx;

  // Shadow of the software view; cnt counts cycles since the last write
  always_comb
  begin
    wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;
    idx = wb_adr_i[5:2];
    w0 = wr & wb_sel_i[0];
    w1 = wr & wb_sel_i[1];
    cnt_next = wr ? 4'h0 : cnt_reg + {3'h0, cnt_reg != 4'hf};
    div_next = (w0 && idx == `CPO_IDX_XCFG) ? wb_dat_i[1:0] : div_reg;
    sel_next = (w0 && idx == `CPO_IDX_XCFG) ? wb_dat_i[6] : sel_reg;
    mux_next = (w0 && idx == `CPO_IDX_MUX) ? wb_dat_i[0] : mux_reg;
    xoff_next = (w1 && idx == `CPO_IDX_CCTL) ? wb_dat_i[13] : xoff_reg;
    xtal_next = (w1 && idx == `CPO_IDX_CCTL) ? wb_dat_i[14] : xtal_reg;
    pin_v = sel_reg ? shared_pin_19_in : shared_pin_38_in;
  end

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      {cnt_reg, div_reg, sel_reg, mux_reg, xoff_reg, xtal_reg} <= '0;
    else
      {cnt_reg, div_reg, sel_reg, mux_reg, xoff_reg, xtal_reg} <=
        {cnt_next, div_next, sel_next, mux_next, xoff_next, xtal_next};

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_run(logic [1:0] code);
    cnt_reg >= 4'h8 && mux_reg && div_reg == code;
  endsequence

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  property p_pin_gate;
    cnt_reg >= 4'h2 |-> shared_pin_18_oe == mux_reg && (shared_pin_18_oe || !shared_pin_18_out);
  endproperty
  property p_off;
    s_run(2'h3) |-> !shared_pin_18_out;
  endproperty
  property p_full;
    s_run(2'h2) |-> shared_pin_18_out != $past(shared_pin_18_out);
  endproperty
  property p_half;
    s_run(2'h1) |-> shared_pin_18_out != $past(shared_pin_18_out, 2);
  endproperty
  property p_quarter;
    s_run(2'h0) |-> shared_pin_18_out != $past(shared_pin_18_out, 4);
  endproperty
  property p_pinsel;
    cnt_reg >= 4'h8 && $past(pin_v, 2) == $past(pin_v, 4) |->
      external_oscillator_input == (!xoff_reg && $past(pin_v, 3));
  endproperty
  property p_xtal;
    cnt_reg >= 4'h2 |-> crystal_osc_enable == !xtal_reg;
  endproperty

  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  a_pin_gate: assert property (p_pin_gate) else $error("pin 18 gating wrong");
  a_off: assert property (p_off) else $error("clock output not stopped");
  a_full: assert property (p_full) else $error("full rate wrong");
  a_half: assert property (p_half) else $error("half rate wrong");
  a_quarter: assert property (p_quarter) else $error("quarter rate wrong");
  a_pinsel: assert property (p_pinsel) else $error("oscillator pin wrong");
  a_xtal: assert property (p_xtal) else $error("crystal enable wrong");
endmodule

bind cpo_clock_pin_ctrl cpo_props u_props (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .shared_pin_19_in,
  .shared_pin_38_in, .shared_pin_18_out, .shared_pin_18_oe, .external_oscillator_input,
  .crystal_osc_enable);

// >>> test/cpo_osc_model.sv
/* Board oscillators on pins 19 and 38.
   Assumes run from the bench; phases are unrelated to the system clock. */
`timescale 1ns/1ps
module cpo_osc_model
(
  input  wire logic run,
  output logic      shared_pin_19_in,
  output logic      shared_pin_38_in
);
  logic tog19 = 1'b0;
  logic tog38 = 1'b1;
  logic flip  = 1'b0;

  always #137 if (run) tog19 = ~tog19;
  always #211 if (run) tog38 = ~tog38;
  // No pull on these lines: once released they show the inverse, not a stale level
  always @(negedge run)
  begin
    if ($realtime > 0)
    begin
      flip = ~flip;
    end
  end

  // One driver per pin: the running phase combined with the release flip
  assign shared_pin_19_in = tog19 ^ flip;
  assign shared_pin_38_in = tog38 ^ flip;
endmodule

// >>> test/tb.sv
/* Self-checking bench for the clock pin controller.
   Assumes the oscillator model on pins 19 and 38 and a Wishbone master here. */
`timescale 1ns/1ps
`include "cpo_defs.svh"
module tb
  import cpo_pkg::*;
;
  logic                  clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, run;
  logic [`CPO_ADR_W-1:0] wb_adr_i;
  logic [3:0]            wb_sel_i;
  logic [31:0]           wb_dat_i, wb_dat_o;
  logic                  shared_pin_19_in, shared_pin_38_in, shared_pin_18_out;
  logic                  shared_pin_18_oe, external_oscillator_input, crystal_osc_enable;
  int                    num_errors = 0;
  int                    checked = 0;

  cpo_clock_pin_ctrl dut (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .shared_pin_19_in, .shared_pin_38_in,
    .shared_pin_18_out, .shared_pin_18_oe, .external_oscillator_input, .crystal_osc_enable);
  cpo_osc_model osc (.run, .shared_pin_19_in, .shared_pin_38_in);

  always #12.5 clock = ~clock;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (wb_ack_o !== 1'b1)
    begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  task automatic toggles(output logic [31:0] n);
    logic prev;
    n = 0;
    prev = shared_pin_18_out;
    repeat (32)
    begin
      @(posedge clock);
      n += {31'h0, shared_pin_18_out !== prev};
      prev = shared_pin_18_out;
    end
  endtask

  task automatic t_reset;
    rd(6'h00, `CPO_XCFG_RST);
    rd(6'h04, `CPO_CCTL_RST);
    rd(6'h08, `CPO_MUX_RST);
    rd(6'h10, 32'h0000_0000);
    chk({31'h0, crystal_osc_enable}, 32'h0000_0001);
  endtask

  task automatic t_rates;
    logic [31:0] n;
    logic [31:0] exp [4] = '{32'h0000_0008, 32'h0000_0010, 32'h0000_0020, 32'h0000_0000};
    wr(6'h08, 32'h0000_0001);
    for (int i = 0; i < 4; i++)
    begin
      wr(6'h00, i);
      repeat (8) @(posedge clock);
      toggles(n);
      chk(n, exp[i]);
      chk({31'h0, shared_pin_18_oe}, 32'h0000_0001);
    end
    wr(6'h00, 32'h0000_0002);
    wr(6'h08, 32'h0000_0000);
    repeat (2) @(posedge clock);
    toggles(n);
    chk(n, 32'h0000_0000);
    chk({31'h0, shared_pin_18_oe}, 32'h0000_0000);
  endtask

  task automatic t_pins;
    run <= 1'b1;
    repeat (100) @(posedge clock);
    run <= 1'b0;
    repeat (5) @(posedge clock);
    chk({31'h0, external_oscillator_input}, {31'h0, shared_pin_38_in});
    wr(6'h00, 32'h0000_0040);
    // Run length picked so pin 19 ends high and pin 38 low: a wrong pick or
    // a dead disable would then show
    run <= 1'b1;
    repeat (90) @(posedge clock);
    run <= 1'b0;
    repeat (5) @(posedge clock);
    chk({31'h0, external_oscillator_input}, {31'h0, shared_pin_19_in});
    wr(6'h04, 32'h0000_2000);
    repeat (5) @(posedge clock);
    chk({31'h0, external_oscillator_input}, 32'h0000_0000);
    wr(6'h00, 32'h0000_0043);
    rd(6'h0C, {26'h0, 1'b0, shared_pin_38_in, shared_pin_19_in, 1'b0, 2'h3});
    wr(6'h04, 32'h0000_4000);
    repeat (3) @(posedge clock);
    chk({31'h0, crystal_osc_enable}, 32'h0000_0000);
    rd(6'h04, 32'h0000_4000);
    rd(6'h00, 32'h0000_0043);
  endtask

  initial
  begin
    {clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, run} = 6'h00;
    wb_adr_i = 6'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0000_0000;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_rates();
    t_pins();
    complete_run();
  end
endmodule
